// [verilog/pcs_pkg.sv]
// package: register map, field positions and types of the phy control/status bank
//
// Function
// - speed select bit 13: one runs 100 Mb/s, zero runs 10 Mb/s.
// - duplex bit 8 resets to one; one full duplex, zero half.
// - duplex bit writable by software and updated by auto-negotiation result.
// - collision test bit 7 raises collision during transmission, drops after.
// - status register at offset 0x01, read-only, resets to 0x7849.
// - status bits 14..11 always one: 100 full, 100 half, 10 full, 10 half.
// - status bit 6 reads one: preamble may be omitted by controller.
// - status bit 5 set when auto-negotiation done; resets to zero.
// - status bit 4 sticky remote fault, cleared by status read.
// - status bit 3 always one: auto-negotiation able.
// - status bit 2 is link up; resets to zero.
// - status bit 1 sticky jabber, cleared by status read.
// - status bit 0 always one: extended registers present.
// - status bits 31..15 and 10..7 reserved, read zero.
package pcs_pkg;
  localparam logic [4:0] PCS_OFF_CONTROL = 5'h00;
  localparam logic [4:0] PCS_OFF_STATUS = 5'h01;
  localparam logic [15:0] PCS_CONTROL_RESET = 16'h3100;
  localparam logic [15:0] PCS_STATUS_RESET = 16'h7849;
  localparam int PCS_BIT_SPEED = 13;
  localparam int PCS_BIT_AN_EN = 12;
  localparam int PCS_BIT_POWER_DOWN = 11;
  localparam int PCS_BIT_ISOL = 10;
  localparam int PCS_BIT_AN_RST = 9;
  localparam int PCS_BIT_DUPLEX = 8;
  localparam int PCS_BIT_COLTEST = 7;
  localparam int PCS_BIT_REMOTE_FAULT = 4;
  localparam int PCS_BIT_LINK = 2;
  localparam int PCS_BIT_JABBER = 1;
  localparam int PCS_BIT_AN_DONE = 5;
  // fixed ones of status: caps 14..11, preamble 6, autoneg able 3, ext 0
  localparam logic [15:0] PCS_STATUS_FIXED = 16'h7849;
  // autoneg run length, in cycles, for the restart handshake model
  localparam int PCS_AN_CYCLES = 16;

  typedef struct packed {
    logic speed_select;
    logic autoneg_enable;
    logic power_down;
    logic isolate;
    logic autoneg_restart;
    logic duplex;
    logic collision_test;
    logic [6:0] spare;
  } pcs_control_t;

  typedef struct packed {
    logic remote_fault;
    logic jabber_seen;
    logic link_up;
    logic autoneg_done;
  } pcs_status_t;

  typedef enum logic [1:0] {
    AN_IDLE = 2'b00,
    AN_RUN = 2'b01,
    AN_DONE = 2'b10
  } pcs_an_state_t;
endpackage : pcs_pkg

// [verilog/pcs_sync.sv]
// file: three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module pcs_sync
  import pcs_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } pcs_sync_st_t;

  pcs_sync_st_t st_ff;
  pcs_sync_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // first flop feeds only the second; level moves when 2 and 3 agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.lvl[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.lvl;
endmodule // pcs_sync

// [verilog/pcs_regs.sv]
// file: phy control and status register bank behind the management port
`timescale 1ns/10ps
module pcs_regs
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // management register port
  input wire logic [4:0] mgmt_addr_in,
  input wire logic mgmt_wr_in,
  input wire logic mgmt_rd_in,
  input wire logic [15:0] mgmt_wdata_in,
  output logic [31:0] mgmt_rdata_out,
  // medium-side events, asynchronous pins
  input wire logic link_pin_in,
  input wire logic remote_fault_pin_in,
  input wire logic jabber_pin_in,
  input wire logic tx_active_pin_in,
  input wire logic partner_full_pin_in,
  // controls to the phy core
  output logic speed_100_out,
  output logic autoneg_run_out,
  output logic autoneg_start_out,
  output logic power_down_out,
  output logic isolate_out,
  output logic full_duplex_out,
  output logic collision_out
);
  typedef struct packed {
    pcs_control_t ctl;
    pcs_status_t sts;
    pcs_an_state_t an;
    logic [4:0] an_cnt;
    logic start;
    logic coll;
    logic [31:0] rdata;
  } pcs_st_t;

  pcs_st_t st_ff;
  pcs_st_t nxt_st;
  logic [4:0] pin_lvl;
  logic [15:0] status_word;

  pcs_sync #(
    .WIDTH(5)
  ) u_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pin_in({partner_full_pin_in, tx_active_pin_in, jabber_pin_in,
             remote_fault_pin_in, link_pin_in}),
    .level_out(pin_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    status_word = PCS_STATUS_FIXED;
    status_word[PCS_BIT_AN_DONE] = st_ff.sts.autoneg_done;
    status_word[PCS_BIT_REMOTE_FAULT] = st_ff.sts.remote_fault;
    status_word[PCS_BIT_LINK] = st_ff.sts.link_up;
    status_word[PCS_BIT_JABBER] = st_ff.sts.jabber_seen;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.sts.link_up = pin_lvl[0];
    // read of status clears sticky flags; a new event the same cycle wins
    if (mgmt_rd_in && mgmt_addr_in == PCS_OFF_STATUS) begin
      nxt_st.sts.remote_fault = 1'b0;
      nxt_st.sts.jabber_seen = 1'b0;
    end
    if (pin_lvl[1]) begin
      nxt_st.sts.remote_fault = 1'b1;
    end
    if (pin_lvl[2]) begin
      nxt_st.sts.jabber_seen = 1'b1;
    end
    nxt_st.rdata = '0;
    if (mgmt_rd_in) begin
      case (mgmt_addr_in)
        PCS_OFF_CONTROL: nxt_st.rdata = {18'h0_0000, st_ff.ctl};
        PCS_OFF_STATUS: nxt_st.rdata = {16'h0000, status_word};
        default: nxt_st.rdata = '0;
      endcase
    end
    // status is read-only: writes to its offset are ignored
    if (mgmt_wr_in && mgmt_addr_in == PCS_OFF_CONTROL) begin
      // bits 15..14 are not held in this bank
      nxt_st.ctl = mgmt_wdata_in[13:0];
      nxt_st.ctl.spare = '0;
    end
    // collision follows transmit activity while the test mode is set
    nxt_st.coll = st_ff.ctl.collision_test && pin_lvl[3];
    case (st_ff.an)
      AN_IDLE: begin
        if (st_ff.ctl.autoneg_enable && !st_ff.ctl.power_down) begin
          nxt_st.an = AN_RUN;
          nxt_st.an_cnt = '0;
          nxt_st.start = 1'b1;
        end
      end
      AN_RUN: begin
        nxt_st.an_cnt = st_ff.an_cnt + 5'h01;
        if (st_ff.an_cnt == 5'(PCS_AN_CYCLES - 1) && pin_lvl[0]) begin
          nxt_st.an = AN_DONE;
          nxt_st.sts.autoneg_done = 1'b1;
          nxt_st.ctl.duplex = pin_lvl[4];
        end else if (st_ff.an_cnt == 5'(PCS_AN_CYCLES - 1)) begin
          nxt_st.an_cnt = '0;
        end
      end
      AN_DONE: begin
        if (!pin_lvl[0]) begin
          nxt_st.an = AN_IDLE;
          nxt_st.sts.autoneg_done = 1'b0;
        end
      end
      default: nxt_st.an = AN_IDLE;
    endcase
    if (!st_ff.ctl.autoneg_enable) begin
      nxt_st.an = AN_IDLE;
      nxt_st.sts.autoneg_done = 1'b0;
    end
    // restart: drop completion, begin anew, self-clear the bit
    if (st_ff.ctl.autoneg_restart) begin
      nxt_st.an = AN_IDLE;
      // idle start pulse is dropped: the fresh run pulses one cycle later
      nxt_st.start = 1'b0;
      nxt_st.sts.autoneg_done = 1'b0;
      nxt_st.ctl.autoneg_restart = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '{ctl: PCS_CONTROL_RESET[13:0], sts: '0, an: AN_IDLE,
                 an_cnt: 5'h00, start: 1'b0, coll: 1'b0, rdata: 32'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign mgmt_rdata_out = st_ff.rdata;
  assign speed_100_out = st_ff.ctl.speed_select;
  assign autoneg_run_out = st_ff.an == AN_RUN;
  assign autoneg_start_out = st_ff.start;
  assign power_down_out = st_ff.ctl.power_down;
  assign isolate_out = st_ff.ctl.isolate;
  assign full_duplex_out = st_ff.ctl.duplex;
  assign collision_out = st_ff.coll;
endmodule // pcs_regs

// [tb/pcs_regs_monitor.sv]
// checker of the phy control/status bank ports
`timescale 1ns/10ps
module pcs_regs_monitor (
  // clock, reset, management
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [4:0] mgmt_addr_in,
  input wire logic mgmt_rd_in,
  input wire logic [31:0] mgmt_rdata_out,
  // pins and outputs
  input wire logic link_pin_in,
  input wire logic remote_fault_pin_in,
  input wire logic jabber_pin_in,
  input wire logic tx_active_pin_in,
  input wire logic autoneg_start_out,
  input wire logic collision_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence rd_st; mgmt_rd_in && mgmt_addr_in == 5'h01; endsequence
  // pins quiet long enough to drain the synchroniser
  sequence quiet_st;
    (!remote_fault_pin_in && !jabber_pin_in)[*6] ##0 rd_st ##1 rd_st;
  endsequence
  ////////////////////////////////////////
  idle_zero_a:
    assert property (!mgmt_rd_in |=> mgmt_rdata_out == 32'h0)
    else $error("idle data not zero");
  unmapped_zero_a:
    assert property (mgmt_rd_in && mgmt_addr_in > 5'h01 |=> !mgmt_rdata_out)
    else $error("unmapped read not zero");
  status_fixed_a:
    assert property (rd_st |=> (mgmt_rdata_out & 32'hffffffc9) == 32'h7849)
    else $error("status fixed bits wrong");
  ctrl_zero_a:
    assert property (mgmt_rd_in && mgmt_addr_in == 5'h00
      |=> (mgmt_rdata_out & 32'hffff007f) == 32'h0) else $error("spare set");
  sticky_clear_a:
    assert property (quiet_st |=> (mgmt_rdata_out & 32'h12) == 32'h0)
    else $error("sticky bits not cleared");
  link_state_a:
    assert property ($stable(link_pin_in)[*8] ##0 rd_st
      |=> mgmt_rdata_out[2] == $past(link_pin_in)) else $error("link bit");
  coll_quiet_a:
    assert property ((!tx_active_pin_in)[*6] |=> !collision_out)
    else $error("collision without transmit");
  start_pulse_a:
    assert property (autoneg_start_out |=> !autoneg_start_out)
    else $error("start pulse too long");
endmodule // pcs_regs_monitor
bind pcs_regs pcs_regs_monitor i_mon (.clock_in, .rst_in, .mgmt_addr_in,
  .mgmt_rd_in, .mgmt_rdata_out, .link_pin_in, .remote_fault_pin_in,
  .jabber_pin_in, .tx_active_pin_in, .autoneg_start_out, .collision_out);

// [tb/pcs_mac_model.sv]
// far-side model: management master of the phy register bank
`timescale 1ns/10ps
module pcs_mac_model (
  // clock
  input wire logic clock_in,
  // management port
  output logic [4:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] wdata_out,
  input wire logic [31:0] rdata_in
);
  initial begin
    addr_out = 5'h15;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'h0;
  end
  ////////////////////////////////////////
  task automatic wr(logic [4:0] a, logic [15:0] v);
    @(posedge clock_in);
    #1 addr_out = a;
    wdata_out = v & 16'hff80;
    wr_out = 1'b1;
    @(posedge clock_in);
    #1 wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~v;
  endtask
  // hold leaves the read up so the next call reads back to back
  task automatic rd(logic [4:0] a, bit hold, output logic [31:0] d);
    @(posedge clock_in);
    #1 addr_out = a;
    rd_out = 1'b1;
    @(posedge clock_in);
    #1 d = rdata_in;
    if (!hold) begin
      rd_out = 1'b0;
      addr_out = ~a;
    end
  endtask
endmodule // pcs_mac_model

// [tb/tb.sv]
// bench of the phy control/status bank
`timescale 1ns/10ps
module tb;
  logic clock_in = 0, rst_in = 1, ln = 0, rf = 0, jb = 0, tx = 0, pf = 1;
  logic wr, rd, spd, pd, iso, fd, st, col, run;
  logic [4:0] ad;
  logic [15:0] wd, v;
  logic [31:0] rdat, d, seed = 32'h8a21;
  int failures = 0, checks = 0;
  bit seen;
  initial forever #20 clock_in = ~clock_in;
  pcs_regs i_dut (.clock_in, .rst_in, .mgmt_addr_in(ad), .mgmt_wr_in(wr),
    .mgmt_rd_in(rd), .mgmt_wdata_in(wd), .mgmt_rdata_out(rdat),
    .link_pin_in(ln), .remote_fault_pin_in(rf), .jabber_pin_in(jb),
    .tx_active_pin_in(tx), .partner_full_pin_in(pf), .speed_100_out(spd),
    .autoneg_run_out(run), .autoneg_start_out(st), .power_down_out(pd),
    .isolate_out(iso), .full_duplex_out(fd), .collision_out(col));
  pcs_mac_model i_mac (.clock_in, .addr_out(ad), .wr_out(wr), .rd_out(rd),
    .wdata_out(wd), .rdata_in(rdat));
  ////////////////////////////////////////
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(logic [4:0] a, logic [31:0] exp);
    i_mac.rd(a, 1'b0, d);
    chk(d, exp);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(3);
    rst_in = 0;
    rdc(5'h00, 32'h3100);
    rdc(5'h01, 32'h7849);
    rdc(5'h1f, 32'h0);
    i_mac.wr(5'h01, 16'h0);
    rdc(5'h01, 32'h7849);
    $display("reset test done");
    repeat (20) begin
      seed = xs(seed);
      v = seed[15:0] & 16'h3d80;
      i_mac.wr(5'h00, v);
      rdc(5'h00, {16'h0, v});
      chk({spd, pd, iso, fd}, {v[13], v[11:10], v[8]});
    end
    i_mac.wr(5'h00, 16'h1200);
    seen = 0;
    repeat (4) begin
      seen |= st;
      cyc(1);
    end
    chk(seen, 1);
    chk(run, 1);
    rdc(5'h00, 32'h1000);
    ln = 1;
    for (int i = 0; i < 40 && !d[5]; i++) i_mac.rd(5'h01, 1'b0, d);
    chk(d, 32'h786d);
    if (d[5] !== 1'b1) tally_and_finish();
    rdc(5'h00, 32'h1100);
    $display("control test done");
    rf = 1;
    jb = 1;
    cyc(6);
    rf = 0;
    jb = 0;
    cyc(8);
    i_mac.rd(5'h01, 1'b1, d);
    chk(d, 32'h787f);
    rdc(5'h01, 32'h786d);
    i_mac.wr(5'h00, 16'h0080);
    tx = 1;
    cyc(6);
    chk(col, 1);
    tx = 0;
    cyc(6);
    chk(col, 0);
    chk(run, 0);
    $display("event test done");
    tally_and_finish();
  end
endmodule // tb
